/* File: design/tape_seq_pkg.sv */
// Summary of operation
// [R1] write pre/post delays per table at 25 ips
// [R2] read pre/post delays per table at 25 ips
// [R3] delays scale inversely with tape speed
// [R4] transport starts/stops within 15 ms ramps
// [R5] dual stack write ends on record gap
// [R6] no direction or read/write change while moving
// [R7] simple spacing: wait one stop time
// [R8] same type and direction may restart at once
// [R9] write error: backspace, rewrite with normal delays
// [R10] start sets load point or normal flag
// [R11] 9-bit counter decode clears flag and counter
// [R12] one begin-transfer pulse after pre delay
// [R13] end-of-transfer sets post flag, times post delay
// [R14] stop pulse drops motion command
// [R15] speed handled only by counter clock rate
// [R16] chain adapter reports format, head, speed; this project has no chain adapter
// [R17] format and head settings held per command
package tape_seq_pkg;

  // ******************************************************************
  // timing base
  // ******************************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_UNIT_MS = 1; // one counter step = 1 ms at 25 ips
  // cycles per counter step at the reference speed
  localparam int unsigned TICK_REF_CYCLES_DEF = CLK_HZ / 1000 * TICK_UNIT_MS;
  localparam int unsigned SPEED_W = 9; // tape speed in quarter ips
  localparam logic [SPEED_W-1:0] REF_SPEED_Q = 9'h064; // 25 ips
  localparam int unsigned CNT_W = 9;
  localparam int unsigned ACC_W = 32;

  // ******************************************************************
  // delays in ms at 25 ips, equal to counter steps
  // ******************************************************************
  localparam logic [CNT_W-1:0] PRE_WR_LP = 9'h0E2; // 226
  localparam logic [CNT_W-1:0] PRE_WR_MARK = 9'h096; // 150
  localparam logic [CNT_W-1:0] PRE_WR_S9 = 9'h017; // 23
  localparam logic [CNT_W-1:0] PRE_WR_S7 = 9'h01C; // 28
  localparam logic [CNT_W-1:0] PRE_WR_D9 = 9'h011; // 17
  localparam logic [CNT_W-1:0] PRE_WR_D7 = 9'h016; // 22
  localparam logic [CNT_W-1:0] PRE_RD_LP = 9'h03C; // 60
  localparam logic [CNT_W-1:0] PRE_RD = 9'h00C; // 12
  localparam logic [CNT_W-1:0] POST_WR = 9'h003; // 3
  localparam logic [CNT_W-1:0] POST_RD_FWD = 9'h000; // 0
  localparam logic [CNT_W-1:0] POST_REV9 = 9'h003; // 3
  localparam logic [CNT_W-1:0] POST_REV7 = 9'h008; // 8
  localparam logic [CNT_W-1:0] POST_EDIT9 = 9'h008; // 8
  localparam logic [CNT_W-1:0] POST_EDIT7 = 9'h00D; // 13
  localparam logic [CNT_W-1:0] STOP_TIME = 9'h00F; // 15 start/stop time

  // ******************************************************************
  // types
  // ******************************************************************
  typedef enum logic [2:0] {
    OP_WRITE, OP_WRITE_MARK, OP_READ_FWD, OP_READ_REV, OP_READ_EDIT
  } op_e;
  typedef enum logic [1:0] {PH_IDLE, PH_PRE, PH_XFER, PH_POST} phase_e;
  typedef enum logic [1:0] {RT_NONE, RT_BACK, RT_REWRITE} retry_e;

  function automatic logic is_write(input op_e op);
    return (op == OP_WRITE) || (op == OP_WRITE_MARK);
  endfunction

  function automatic logic is_rev(input op_e op);
    return (op == OP_READ_REV) || (op == OP_READ_EDIT);
  endfunction

  // pre-record decode by command kind, load point, format and head
  function automatic logic [CNT_W-1:0] pre_delay(input op_e op, input logic lp,
                                                 input logic t7, input logic dual);
    logic [CNT_W-1:0] v;
    v = lp ? PRE_RD_LP : PRE_RD;
    if (is_write(op)) begin
      if (lp) begin
        v = PRE_WR_LP;
      end else if (op == OP_WRITE_MARK) begin
        v = PRE_WR_MARK;
      end else if (dual) begin
        v = t7 ? PRE_WR_D7 : PRE_WR_D9;
      end else begin
        v = t7 ? PRE_WR_S7 : PRE_WR_S9;
      end
    end
    return v;
  endfunction

  // post-record decode
  function automatic logic [CNT_W-1:0] post_delay(input op_e op, input logic t7);
    logic [CNT_W-1:0] v;
    v = POST_RD_FWD;
    if (is_write(op)) begin
      v = POST_WR;
    end else if (op == OP_READ_REV) begin
      v = t7 ? POST_REV7 : POST_REV9;
    end else if (op == OP_READ_EDIT) begin
      v = t7 ? POST_EDIT7 : POST_EDIT9;
    end
    return v;
  endfunction

endpackage

/* File: design/tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ******************************************************************
// speed setting in, counter step out
// ******************************************************************
interface tick_if;
  import tape_seq_pkg::*;
  logic [SPEED_W-1:0] speed_q;
  logic tick;
  modport src (input speed_q, output tick);
  modport snk (output speed_q, input tick);
endinterface
`default_nettype wire

/* File: design/rate_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module rate_tick
  import tape_seq_pkg::*;
#(
  parameter int unsigned TICK_REF_CYCLES = TICK_REF_CYCLES_DEF
) (
  input wire logic ref_clk_i, // 20 MHz clock
  input wire logic rst_n_i, // async reset, low
  tick_if.src tk // speed in, step out
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic tick;
  } rate_s;

  localparam logic [ACC_W-1:0] LIMIT = ACC_W'(REF_SPEED_Q * TICK_REF_CYCLES);

  rate_s s;
  rate_s next_s;
  logic [ACC_W-1:0] sum;

  // fractional accumulator: step rate exactly proportional to speed
  always_comb begin
    next_s = s;
    sum = s.acc + ACC_W'(tk.speed_q);
    next_s.tick = 1'b0;
    next_s.acc = sum;
    if (sum >= LIMIT) begin
      next_s.acc = sum - LIMIT; // keep the remainder, no drift
      next_s.tick = 1'b1; // [R3] [R15]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tk.tick = s.tick;

  // a step is a single cycle at speeds up to the reference speed
  tick_single_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R15]
    s.tick && (tk.speed_q <= REF_SPEED_Q) |=> !s.tick)
    else $error("counter step longer than one cycle");

endmodule
`default_nettype wire

/* File: design/tape_motion_delay_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module tape_motion_delay_sequencer
  import tape_seq_pkg::*;
#(
  parameter int unsigned TICK_REF_CYCLES = TICK_REF_CYCLES_DEF
) (
  input wire logic ref_clk_i, // 20 MHz clock
  input wire logic rst_n_i, // async reset, low
  input wire logic [SPEED_W-1:0] speed_qips_i, // tape speed, quarter ips
  input wire logic track7_i, // 1 = 7-track format
  input wire logic dual_stack_i, // 1 = dual-stack head
  input wire logic tape_load_point_i, // tape at load point
  input wire logic cmd_valid_i, // command request
  input wire op_e cmd_op_i, // command kind
  output logic cmd_ready_o, // command taken when valid
  input wire logic end_data_i, // end of transfer / record gap seen
  input wire logic write_error_i, // write check failed, with end_data_i
  output logic forward_motion_cmd_o, // forward motion to transport
  output logic reverse_motion_cmd_o, // reverse motion to transport
  output logic write_status_o, // write mode to transport
  output logic begin_data_o, // pulse: start data transfer
  output logic done_o, // pulse: command finished, tape stopping
  output logic stopped_o // tape known to be at rest
);

  // ******************************************************************
  // state
  // ******************************************************************
  typedef struct packed {
    phase_e phase;
    op_e op;
    retry_e retry;
    logic load_point_delay_flag;
    logic normal_delay_flag;
    logic post_delay_flag;
    logic fwd;
    logic rev;
    logic last_rev;
    logic wstat;
    logic t7;
    logic dual;
    logic err;
    logic stopped;
    logic begin_p;
    logic done_p;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] stop_cnt;
  } seq_s;

  seq_s s;
  seq_s next_s;
  logic tick;
  op_e sel_op;
  logic want;
  logic may_go;
  logic launch;
  logic [CNT_W-1:0] pre_t;
  logic [CNT_W-1:0] post_t;

  tick_if tk ();

  assign tk.speed_q = speed_qips_i;
  assign tick = tk.tick;

  // counter clock follows tape speed; nothing else depends on speed
  rate_tick #(
    .TICK_REF_CYCLES(TICK_REF_CYCLES)
  ) u_rate (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .tk(tk)
  );

  // ******************************************************************
  // command selection and separation
  // ******************************************************************
  // a pending retry takes precedence over the user
  always_comb begin
    unique case (s.retry)
      RT_BACK: sel_op = OP_READ_REV; // [R9]
      RT_REWRITE: sel_op = OP_WRITE; // [R9]
      default: sel_op = cmd_op_i;
    endcase
  end

  assign want = (s.retry != RT_NONE) || cmd_valid_i;
  // restart while decelerating only for same kind and direction
  assign may_go = s.stopped || // [R6] [R7]
                  ((is_write(sel_op) == s.wstat) && (is_rev(sel_op) == s.last_rev)); // [R8]
  assign launch = (s.phase == PH_IDLE) && want && may_go;
  assign cmd_ready_o = (s.phase == PH_IDLE) && (s.retry == RT_NONE) && may_go;

  // decode of the current command, settings latched at start
  assign pre_t = pre_delay(s.op, s.load_point_delay_flag, s.t7, s.dual); // [R1] [R2] [R17]
  assign post_t = post_delay(s.op, s.t7); // [R1] [R2] [R17]

  // ******************************************************************
  // sequencer
  // ******************************************************************
  always_comb begin
    next_s = s;
    next_s.begin_p = 1'b0;
    next_s.done_p = 1'b0;
    // stop timer runs only while no motion command is up
    if (!s.fwd && !s.rev && !s.stopped && tick) begin
      if (s.stop_cnt + 9'h001 >= STOP_TIME) begin
        next_s.stopped = 1'b1; // [R7]
      end else begin
        next_s.stop_cnt = s.stop_cnt + 9'h001;
      end
    end
    unique case (s.phase)
      PH_IDLE: begin
        if (launch) begin
          next_s.op = sel_op;
          next_s.fwd = !is_rev(sel_op);
          next_s.rev = is_rev(sel_op);
          next_s.last_rev = is_rev(sel_op);
          next_s.wstat = is_write(sel_op);
          next_s.t7 = track7_i; // [R17]
          next_s.dual = dual_stack_i; // [R17]
          next_s.stopped = 1'b0;
          next_s.stop_cnt = '0;
          next_s.cnt = '0;
          // retries use normal delays so each lands farther on
          next_s.load_point_delay_flag = tape_load_point_i && (s.retry == RT_NONE); // [R10]
          next_s.normal_delay_flag = !(tape_load_point_i && (s.retry == RT_NONE)); // [R10]
          next_s.phase = PH_PRE;
          if (s.retry == RT_BACK) begin
            next_s.retry = RT_REWRITE; // [R9]
          end else begin
            next_s.retry = RT_NONE;
          end
        end
      end
      PH_PRE: begin
        if (s.cnt >= pre_t) begin
          next_s.load_point_delay_flag = 1'b0; // [R11]
          next_s.normal_delay_flag = 1'b0;
          next_s.cnt = '0;
          next_s.begin_p = 1'b1; // [R12]
          next_s.phase = PH_XFER;
        end else if (tick) begin
          next_s.cnt = s.cnt + 9'h001; // [R11]
        end
      end
      PH_XFER: begin
        // for dual stack the caller raises this on the record gap
        if (end_data_i) begin
          next_s.post_delay_flag = 1'b1; // [R13] [R5]
          next_s.err = write_error_i && s.wstat; // [R9]
          next_s.cnt = '0;
          next_s.phase = PH_POST;
        end
      end
      PH_POST: begin
        if (s.cnt >= post_t) begin
          next_s.post_delay_flag = 1'b0;
          next_s.fwd = 1'b0; // [R14]
          next_s.rev = 1'b0; // [R14]
          next_s.done_p = 1'b1;
          next_s.cnt = '0;
          next_s.phase = PH_IDLE;
          if (s.err) begin
            next_s.retry = RT_BACK; // [R9]
          end
          next_s.err = 1'b0;
        end else if (tick) begin
          next_s.cnt = s.cnt + 9'h001; // [R13]
        end
      end
    endcase
  end

  // tape assumed at rest after reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '{phase: PH_IDLE, op: OP_READ_FWD, retry: RT_NONE, stopped: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign forward_motion_cmd_o = s.fwd;
  assign reverse_motion_cmd_o = s.rev;
  assign write_status_o = s.wstat;
  assign begin_data_o = s.begin_p;
  assign done_o = s.done_p;
  assign stopped_o = s.stopped;

  // ******************************************************************
  // checks
  // ******************************************************************
  start_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R10]
    launch |=> (s.load_point_delay_flag != s.normal_delay_flag) && (s.phase == PH_PRE))
    else $error("start did not set exactly one delay flag");

  pre_end_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R11]
    (s.phase == PH_PRE) && (s.cnt >= pre_t) |=> (s.cnt == '0) && begin_data_o
      && !s.load_point_delay_flag && !s.normal_delay_flag)
    else $error("pre delay decode did not clear flag and counter");

  begin_once_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R12]
    begin_data_o |-> $past(s.phase) == PH_PRE ##1 !begin_data_o [*2])
    else $error("begin transfer not a single pulse");

  post_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R13]
    (s.phase == PH_XFER) && end_data_i |=> s.post_delay_flag && (s.cnt == '0))
    else $error("end of transfer did not set post flag");

  stop_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R14]
    s.post_delay_flag && (s.cnt >= post_t) |=> !forward_motion_cmd_o
      && !reverse_motion_cmd_o && done_o)
    else $error("post delay end did not drop motion");

  // judged on the motion outputs, so a wrong launch gate is caught too
  dir_change_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R6]
    $rose(forward_motion_cmd_o || reverse_motion_cmd_o)
      && ($changed(write_status_o) || $changed(s.last_rev)) |-> $past(s.stopped))
    else $error("direction or mode change while tape moving");

  cnt_step_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R3]
    (s.cnt != '0) && (s.cnt != $past(s.cnt)) |-> $past(tick)
      && (s.cnt == $past(s.cnt) + 9'h001))
    else $error("delay counter moved without a step");

  mode_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R17]
    (s.phase != PH_IDLE) && !launch |=> $stable(write_status_o) && $stable(s.t7)
      && $stable(s.dual))
    else $error("mode or format changed inside a command");

  retry_seq_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R9]
    done_o && (s.retry == RT_BACK) |-> !cmd_ready_o)
    else $error("user command accepted before rewrite");

endmodule
`default_nettype wire

/* File: verif/tape_transport_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// transport model
// ****
module tape_transport_model
  import tape_seq_pkg::*;
#(
  parameter int RAMP = 30000 // full speed, speed units times cycles
) (
  input wire logic ref_clk_i, // clock
  input wire logic rst_n_i, // reset, low
  input wire logic [SPEED_W-1:0] speed_qips_i, // tape speed
  input wire logic fwd_i, // forward motion
  input wire logic rev_i, // reverse motion
  input wire logic wr_i, // write status
  input wire logic rewind_i, // put tape at load point
  input wire logic dual_sel_i, // head fitted
  output logic tape_load_point_o, // at load point
  output logic dual_stack_o, // head status
  output logic moving_o, // tape in motion
  output logic [7:0] misuse_o // starts that broke motion rules
);
  int vel;
  logic on_q;
  logic dir_rev;
  logic wr_st;
  assign moving_o = (vel != 0);
  assign dual_stack_o = dual_sel_i;
  // linear ramps; stopping a little early is within the limit
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vel <= 0;
      on_q <= 1'b0;
      dir_rev <= 1'b0;
      wr_st <= 1'b0;
      misuse_o <= 8'h00;
      tape_load_point_o <= 1'b0;
    end else begin
      on_q <= fwd_i | rev_i;
      if (fwd_i | rev_i) begin
        vel <= (vel + speed_qips_i > RAMP) ? RAMP : vel + speed_qips_i;
      end else begin
        vel <= (vel < speed_qips_i * 9 / 8) ? 0 : vel - speed_qips_i * 9 / 8;
      end
      // mode latched at each start, as the transport does
      if ((fwd_i | rev_i) && !on_q) begin
        if (vel != 0 && (rev_i != dir_rev || wr_i != wr_st)) begin
          misuse_o <= misuse_o + 8'h01;
        end
        dir_rev <= rev_i;
        wr_st <= wr_i;
      end
      if (rewind_i) begin
        tape_load_point_o <= 1'b1;
      end else if (fwd_i && vel != 0) begin
        tape_load_point_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/tape_motion_delay_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// sequencer bench
// ****
module tape_motion_delay_sequencer_tb;
  import tape_seq_pkg::*;
  localparam int TK = 20; // short step keeps the run brief
  typedef struct {op_e op; logic lp; logic t7; logic ds; int spd; int pre; int post;} row_s;
  logic ref_clk = 0;
  logic rst_n = 0;
  logic track7 = 0;
  logic dual_sel = 0;
  logic cmd_valid = 0;
  logic end_data = 0;
  logic wr_err = 0;
  logic rewind = 0;
  logic [SPEED_W-1:0] speed = 9'h064;
  op_e cmd_op = OP_WRITE;
  logic cmd_ready, fwd, rev, wr_st, begin_data, done, stopped, lp, dual;
  logic [7:0] misuse;
  int miscompares = 0;
  int n_compared = 0;
  int pc, qc, w, s, lo;
  row_s rows[13];
  always #25 ref_clk = ~ref_clk;
  tape_motion_delay_sequencer #(.TICK_REF_CYCLES(TK)) u_tape_motion_delay_sequencer (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .speed_qips_i(speed), .track7_i(track7),
    .dual_stack_i(dual), .tape_load_point_i(lp), .cmd_valid_i(cmd_valid),
    .cmd_op_i(cmd_op), .cmd_ready_o(cmd_ready), .end_data_i(end_data),
    .write_error_i(wr_err), .forward_motion_cmd_o(fwd), .reverse_motion_cmd_o(rev),
    .write_status_o(wr_st), .begin_data_o(begin_data), .done_o(done), .stopped_o(stopped));
  tape_transport_model u_tape_transport_model (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .speed_qips_i(speed), .fwd_i(fwd), .rev_i(rev),
    .wr_i(wr_st), .rewind_i(rewind), .dual_sel_i(dual_sel), .tape_load_point_o(lp),
    .dual_stack_o(dual), .moving_o(), .misuse_o(misuse));
  task automatic conclude();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string nm, input int lo, input int hi, input int got);
    n_compared++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic chkl(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tmo(input string nm);
    miscompares++;
    $display("Error %s expected event seen timeout", nm);
    conclude();
  endtask
  // request held until ready is seen mid-cycle, wait counted
  task automatic issue(input op_e op, output int n);
    cmd_op = op;
    cmd_valid = 1;
    n = 0;
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 9000) tmo("cmd_ready");
    end
    step();
    cmd_valid = 0;
    step();
  endtask
  // one record: pre delay, transfer end, post delay
  task automatic xfer(input logic err, output int p, output int q);
    p = 0;
    while (begin_data !== 1'b1) begin
      step();
      p++;
      if (p > 12000) tmo("begin_data");
    end
    step();
    chkl("begin_pulse", 0, begin_data);
    end_data = 1;
    wr_err = err;
    step();
    end_data = 0;
    wr_err = 0;
    q = 0;
    while (done !== 1'b1) begin
      step();
      q++;
      if (q > 12000) tmo("done");
    end
    chkl("fwd_at_stop", 0, fwd);
    chkl("rev_at_stop", 0, rev);
  endtask
  task automatic wait_mot(input logic r);
    w = 0;
    while ((r ? rev : fwd) !== 1'b1) begin
      step();
      w++;
      if (w > 9000) tmo("motion");
    end
  endtask
  // settings change only once the tape is at rest
  task automatic run(input int i);
    s = TK * 100 / rows[i].spd;
    w = 0;
    while (stopped !== 1'b1) begin
      step();
      w++;
      if (w > 9000) tmo("stopped");
    end
    speed = rows[i].spd[8:0];
    track7 = rows[i].t7;
    dual_sel = rows[i].ds;
    rewind = rows[i].lp;
    step();
    rewind = 0;
    issue(rows[i].op, w);
    chkl("forward", rows[i].op < OP_READ_REV, fwd);
    chkl("reverse", rows[i].op >= OP_READ_REV, rev);
    chkl("write_status", rows[i].op <= OP_WRITE_MARK, wr_st);
    xfer(0, pc, qc);
    lo = (rows[i].pre - 1) * s;
    chk("pre_delay", lo, rows[i].pre * s + 3, pc);
    lo = rows[i].post == 0 ? 1 : (rows[i].post - 1) * s;
    chk("post_delay", lo, rows[i].post * s + 3, qc);
  endtask
  initial begin
    rows = '{'{OP_WRITE, 1, 0, 0, 100, 226, 3}, '{OP_WRITE_MARK, 0, 0, 0, 100, 150, 3},
             '{OP_WRITE, 0, 0, 0, 100, 23, 3}, '{OP_WRITE, 0, 1, 0, 100, 28, 3},
             '{OP_WRITE, 0, 0, 1, 100, 17, 3}, '{OP_WRITE, 0, 1, 1, 100, 22, 3},
             '{OP_READ_FWD, 1, 0, 0, 100, 60, 0}, '{OP_READ_FWD, 0, 0, 0, 50, 12, 0},
             '{OP_READ_REV, 0, 0, 0, 100, 12, 3}, '{OP_READ_REV, 0, 1, 0, 100, 12, 8},
             '{OP_READ_EDIT, 0, 0, 0, 100, 12, 8}, '{OP_READ_EDIT, 0, 1, 0, 100, 12, 13},
             '{OP_WRITE_MARK, 1, 0, 0, 100, 226, 3}};
    step();
    chkl("rst_stopped", 1, stopped);
    chkl("rst_fwd", 0, fwd);
    chkl("rst_begin", 0, begin_data);
    chkl("rst_ready", 1, cmd_ready);
    step();
    rst_n = 1;
    foreach (rows[i]) run(i);
    // same kind back to back may start while decelerating
    speed = 9'h064;
    track7 = 0;
    dual_sel = 0;
    issue(OP_WRITE, w);
    xfer(0, pc, qc);
    issue(OP_WRITE, w);
    chk("same_kind_wait", 0, 2, w);
    xfer(0, pc, qc);
    issue(OP_READ_FWD, w);
    chk("stop_wait", 14 * TK - 2, 15 * TK + 3, w);
    xfer(0, pc, qc);
    // failed write: back over the record, then rewrite
    issue(OP_WRITE, w);
    xfer(1, pc, qc);
    step();
    chkl("ready_in_retry", 0, cmd_ready);
    wait_mot(1);
    chkl("back_read", 0, wr_st);
    xfer(0, pc, qc);
    chk("back_pre", 11 * TK, 12 * TK + 3, pc);
    chk("back_post", 2 * TK, 3 * TK + 3, qc);
    wait_mot(0);
    chkl("rewrite_mode", 1, wr_st);
    xfer(0, pc, qc);
    chk("rewrite_pre", 22 * TK, 23 * TK + 3, pc);
    // identity compare so an unknown count cannot slip through
    chkl("misuse_none", 1, misuse === 8'h00);
    // reset in mid-command drops motion at once
    issue(OP_READ_FWD, w);
    step();
    rst_n = 0;
    step();
    chkl("mid_rst_fwd", 0, fwd);
    chkl("mid_rst_write", 0, wr_st);
    rst_n = 1;
    // tape taken as at rest again, so a reverse read goes at once
    chkl("mid_rst_stopped", 1, stopped);
    issue(OP_READ_REV, w);
    chk("rst_go_wait", 0, 0, w);
    chkl("rst_rev", 1, rev);
    xfer(0, pc, qc);
    chk("rst_pre", 11 * TK, 12 * TK + 3, pc);
    chk("rst_post", 2 * TK, 3 * TK + 3, qc);
    conclude();
  end
endmodule
`default_nettype wire
